// File: include/epac_pkg.sv
// Constants, register map and types for the EIA port attachment control block.
package epac_pkg;
   // ****************************************
   // Register map.
   // ****************************************
   localparam logic [7:0] EPAC_CTRL_ADDR = 8'h00;
   localparam logic [7:0] EPAC_EVENT_ADDR = 8'h04;
   localparam logic [7:0] EPAC_STATUS_ADDR = 8'h08;
   localparam logic [7:0] EPAC_TOGGLE_ADDR = 8'h0C;
   // Control register fields.
   localparam int EPAC_CTRL_TYPE_LSB = 0;
   localparam int EPAC_CTRL_ROLE_LSB = 2;
   localparam int EPAC_CTRL_OUTBAND_BIT = 4;
   localparam int EPAC_CTRL_DTRTOG_BIT = 5;
   localparam logic [5:0] EPAC_CTRL_RESET = 6'h00;
   // Event register bits, write one to fire.
   localparam int EPAC_EV_SERVICE = 0;
   localparam int EPAC_EV_CONNREQ = 1;
   localparam int EPAC_EV_DENIED = 2;
   localparam int EPAC_EV_QUIT = 3;
   localparam int EPAC_EV_REVERSE = 4;
   localparam int EPAC_EV_GRANTED = 5;
   localparam int EPAC_EV_WIDTH = 6;
   // ****************************************
   // Timing.
   // ****************************************
   localparam longint EPAC_CLK_HZ = 64'd10_000_000;
   localparam longint EPAC_TOGGLE_MIN_MS = 64'd500;
   localparam longint EPAC_TOGGLE_MAX_MS = 64'd1500;
   localparam longint EPAC_TOGGLE_MS = 64'd1000;
   localparam longint EPAC_TOGGLE_CYCLES = EPAC_TOGGLE_MS * EPAC_CLK_HZ / 64'd1000;
   localparam int EPAC_CNT_W = 24;
   // ****************************************
   // Types.
   // ****************************************
   typedef enum logic [1:0]
   {
      EPAC_TYPE_UNQUAL = 2'h0,
      EPAC_TYPE_DTR = 2'h1,
      EPAC_TYPE_MODEM = 2'h2
   } epac_type_t;
   typedef enum logic [1:0]
   {
      EPAC_ROLE_ORIG = 2'h0,
      EPAC_ROLE_ANS = 2'h1,
      EPAC_ROLE_BOTH = 2'h2
   } epac_role_t;
   typedef enum logic [2:0]
   {
      EPAC_ST_NEUTRAL = 3'h0,
      EPAC_ST_PROMPT = 3'h1,
      EPAC_ST_ORIG_CONN = 3'h3,
      EPAC_ST_TOGGLE = 3'h2,
      EPAC_ST_ANS_CONN = 3'h6
   } epac_state_t;
endpackage : epac_pkg

// File: rtl/epac_toggle_timer.sv
// Low-period timer for a control toggle.
`timescale 1ns/10ps
module epac_toggle_timer
   import epac_pkg::*;
#(
   parameter logic [EPAC_CNT_W-1:0] CYCLES = EPAC_CNT_W'(EPAC_TOGGLE_CYCLES)
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Control.
   input wire logic start,
   output logic done
);
   logic [EPAC_CNT_W-1:0] cnt_reg;
   logic run_reg;

   // ****************************************
   // Counter.
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done <= 1'b0;
      end
      else if (start)
      begin
         cnt_reg <= CYCLES - EPAC_CNT_W'(1);
         run_reg <= 1'b1;
         done <= 1'b0;
      end
      else if (run_reg)
      begin
         // Counts CYCLES - 1 clk_sys cycles; the registered state step adds the last low cycle.
         done <= (cnt_reg == EPAC_CNT_W'(1));
         run_reg <= (cnt_reg != EPAC_CNT_W'(1));
         cnt_reg <= cnt_reg - EPAC_CNT_W'(1);
      end
      else
      begin
         done <= 1'b0;
      end
   end
endmodule : epac_toggle_timer

// File: rtl/epac_ahb_slave.sv
// AHB-Lite register slave for the attachment control block.
`timescale 1ns/10ps
module epac_ahb_slave
   import epac_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // AHB-Lite.
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Register side.
   output logic [5:0] ctrl_reg,
   output logic [EPAC_EV_WIDTH-1:0] event_pulse,
   input wire logic [31:0] status_word
);
   logic wr_pend_reg;
   logic [7:0] addr_reg;

   // ****************************************
   // Address phase capture.
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_reg <= hsel && htrans[1] && hwrite;
         addr_reg <= haddr;
      end
   end

   // ****************************************
   // Writes.
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ctrl_reg <= EPAC_CTRL_RESET;
         event_pulse <= '0;
      end
      else
      begin
         event_pulse <= '0;
         if (wr_pend_reg && addr_reg == EPAC_CTRL_ADDR)
         begin
            ctrl_reg <= hwdata[5:0];
         end
         else if (wr_pend_reg && addr_reg == EPAC_EVENT_ADDR)
         begin
            event_pulse <= hwdata[EPAC_EV_WIDTH-1:0];
         end
      end
   end

   // ****************************************
   // Reads, registered in the address phase.
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         if (haddr == EPAC_CTRL_ADDR)
         begin
            hrdata <= {26'h0, ctrl_reg};
         end
         else if (haddr == EPAC_STATUS_ADDR)
         begin
            hrdata <= status_word;
         end
         else if (haddr == EPAC_TOGGLE_ADDR)
         begin
            hrdata <= 32'(EPAC_TOGGLE_CYCLES);
         end
         else
         begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule : epac_ahb_slave

// File: rtl/epac_attach_ctrl.sv
// Top level of the EIA port attachment control block.
`timescale 1ns/10ps
module epac_attach_ctrl
   import epac_pkg::*;
#(
   parameter logic [EPAC_CNT_W-1:0] TOGGLE_CYCLES = EPAC_CNT_W'(EPAC_TOGGLE_CYCLES)
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // AHB-Lite.
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // EIA port.
   input wire logic dtr_in,
   output logic cts_out,
   output logic dsr_out,
   output logic dcd_out,
   // Switch side.
   output logic prompt_pulse,
   output logic grant_pulse,
   output logic attached
);
   logic [5:0] ctrl_reg;
   logic [EPAC_EV_WIDTH-1:0] ev;
   logic [31:0] status_word;
   epac_type_t type_sel;
   epac_role_t role_sel;
   epac_state_t state_reg;
   epac_state_t state_next;
   logic neutral_high;
   logic start_toggle;
   logic toggle_done;
   logic ctl_next;
   logic ans_active;
   logic dtr_ok;

   epac_ahb_slave u_bus
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .ctrl_reg(ctrl_reg),
      .event_pulse(ev),
      .status_word(status_word)
   );

   epac_toggle_timer
   #(
      .CYCLES(TOGGLE_CYCLES)
   )
   u_timer
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .start(start_toggle),
      .done(toggle_done)
   );

   // ****************************************
   // Configuration decode.
   // ****************************************
   // Type and role come from software; outband and DTR toggle bits are stored.
   assign type_sel = epac_type_t'(ctrl_reg[EPAC_CTRL_TYPE_LSB +: 2]);
   assign role_sel = epac_role_t'(ctrl_reg[EPAC_CTRL_ROLE_LSB +: 2]);
   // Originate and both ports idle high, answer ports idle low.
   assign neutral_high = (role_sel != EPAC_ROLE_ANS);
   // A DTR qualified port requires DTR high for a service request only; other types ignore it.
   assign dtr_ok = (type_sel != EPAC_TYPE_DTR) || dtr_in;
   assign ans_active = (state_reg == EPAC_ST_ANS_CONN);
   assign status_word = {24'h0, ctrl_reg[EPAC_CTRL_DTRTOG_BIT], ctrl_reg[EPAC_CTRL_OUTBAND_BIT],
                         dtr_in, state_reg, cts_out, attached};

   // ****************************************
   // Attachment state machine.
   // ****************************************
   always_comb
   begin
      state_next = state_reg;
      start_toggle = 1'b0;
      case (state_reg)
         EPAC_ST_NEUTRAL:
         begin
            // Detached; service request attaches an originate port.
            if (ev[EPAC_EV_SERVICE] && role_sel != EPAC_ROLE_ANS && dtr_ok)
            begin
               state_next = EPAC_ST_PROMPT;
            end
            // Internal connection request toward an answering port.
            else if (ev[EPAC_EV_CONNREQ] && role_sel != EPAC_ROLE_ORIG)
            begin
               state_next = EPAC_ST_ANS_CONN;
            end
         end
         EPAC_ST_PROMPT:
         begin
            if (ev[EPAC_EV_GRANTED])
            begin
               state_next = EPAC_ST_ORIG_CONN;
            end
            else if (ev[EPAC_EV_QUIT])
            begin
               state_next = EPAC_ST_TOGGLE;
               start_toggle = 1'b1;
            end
         end
         EPAC_ST_ORIG_CONN:
         begin
            // User quit toggles the controls.
            if (ev[EPAC_EV_QUIT])
            begin
               state_next = EPAC_ST_TOGGLE;
               start_toggle = 1'b1;
            end
            // Reverse detachment keeps the port attached and prompts.
            else if (ev[EPAC_EV_REVERSE])
            begin
               state_next = EPAC_ST_PROMPT;
            end
         end
         EPAC_ST_ANS_CONN:
         begin
            if (ev[EPAC_EV_QUIT])
            begin
               if (role_sel == EPAC_ROLE_BOTH)
               begin
                  // Both port answering: toggle then high neutral.
                  state_next = EPAC_ST_TOGGLE;
                  start_toggle = 1'b1;
               end
               else
               begin
                  // Answer port drops straight back to low neutral.
                  state_next = EPAC_ST_NEUTRAL;
               end
            end
         end
         EPAC_ST_TOGGLE:
         begin
            if (toggle_done)
            begin
               state_next = EPAC_ST_NEUTRAL;
            end
         end
         default:
         begin
            state_next = EPAC_ST_NEUTRAL;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_reg <= EPAC_ST_NEUTRAL;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // EIA control outputs.
   // ****************************************
   always_comb
   begin
      if (state_next == EPAC_ST_TOGGLE)
      begin
         ctl_next = 1'b0;
      end
      else if (state_next == EPAC_ST_ANS_CONN)
      begin
         ctl_next = 1'b1;
      end
      else
      begin
         ctl_next = neutral_high;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         cts_out <= 1'b0;
         dsr_out <= 1'b0;
         dcd_out <= 1'b1;
      end
      else
      begin
         cts_out <= ctl_next;
         dsr_out <= ctl_next;
         dcd_out <= 1'b1;
      end
   end

   // ****************************************
   // Switch side indications.
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         prompt_pulse <= 1'b0;
         grant_pulse <= 1'b0;
         attached <= 1'b0;
      end
      else
      begin
         // Prompt on attach, on reverse detachment and on denial.
         prompt_pulse <= (state_next == EPAC_ST_PROMPT)
                         && (state_reg != EPAC_ST_PROMPT || ev[EPAC_EV_DENIED]);
         grant_pulse <= (state_reg == EPAC_ST_NEUTRAL) && (state_next == EPAC_ST_ANS_CONN);
         attached <= (state_next != EPAC_ST_NEUTRAL) && (state_next != EPAC_ST_TOGGLE)
                     && !(state_next == EPAC_ST_ANS_CONN && ans_active && 1'b0);
      end
   end
endmodule : epac_attach_ctrl

// File: dv/epac_attach_chk.sv
// Assertion checker for the attachment control block.
`timescale 1ns/10ps
module epac_attach_chk
   import epac_pkg::*;
#(
   parameter logic [23:0] LOW_MIN = 24'h4C4B40,
   parameter logic [23:0] LOW_MAX = 24'hE4E1C0
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // EIA port and switch side.
   input wire logic cts_out,
   input wire logic dsr_out,
   input wire logic dcd_out,
   input wire logic prompt_pulse,
   input wire logic grant_pulse,
   input wire logic attached
);
   logic [23:0] low_cnt_reg;
   // Counts low cycles of the controls; reset preloads LOW_MIN - 1, so the first rise after reset sees LOW_MIN.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         low_cnt_reg <= LOW_MIN - 24'h000001;
      else if (cts_out)
         low_cnt_reg <= 24'h000000;
      else if (low_cnt_reg != 24'hFFFFFF)
         low_cnt_reg <= low_cnt_reg + 24'h000001;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_raised;
      ##[0:1] (cts_out && attached);
   endsequence
   dcd_high_a: assert property (dcd_out)
      else $error("carrier output low");
   ctl_pair_a: assert property (cts_out == dsr_out)
      else $error("cts and dsr differ");
   reset_low_a: assert property ($fell(srst) |-> !cts_out && !attached)
      else $error("levels wrong at reset release");
   toggle_low_a: assert property ($rose(cts_out) && !grant_pulse && !$past(grant_pulse)
      |-> low_cnt_reg >= LOW_MIN && low_cnt_reg <= LOW_MAX)
      else $error("toggle low time out of window");
   prompt_one_a: assert property (prompt_pulse |=> !prompt_pulse && attached)
      else $error("prompt pulse wrong");
   grant_up_a: assert property (grant_pulse |-> s_raised)
      else $error("controls not raised on grant");
   grant_one_a: assert property (grant_pulse |=> !grant_pulse)
      else $error("grant pulse too long");
   drop_detach_a: assert property ($fell(cts_out) |-> ##[0:1] !attached)
      else $error("controls dropped while attached");
endmodule : epac_attach_chk

bind epac_attach_ctrl epac_attach_chk #(.LOW_MIN(TOGGLE_CYCLES), .LOW_MAX(TOGGLE_CYCLES))
   u_chk (.clk_sys(clk_sys), .srst(srst),
   .cts_out(cts_out), .dsr_out(dsr_out), .dcd_out(dcd_out),
   .prompt_pulse(prompt_pulse), .grant_pulse(grant_pulse), .attached(attached));

// File: dv/epac_term_model.sv
// Terminal model on the far side of the EIA port.
`timescale 1ns/10ps
module epac_term_model
(
   // Clock.
   input wire logic clk_sys,
   // EIA port.
   input wire logic cts_out,
   input wire logic dsr_out,
   input wire logic dcd_out,
   output logic dtr_in,
   // Bench control.
   input wire logic dtr_req
);
   // Raises or drops the terminal ready line on request.
   always @(posedge clk_sys)
   begin
      dtr_in <= dtr_req;
   end
endmodule : epac_term_model

// File: dv/epac_attach_ctrl_tb.sv
// Self-checking testbench for the attachment control block.
`timescale 1ns/10ps
module epac_attach_ctrl_tb
   import epac_pkg::*;
;
   typedef struct packed {logic [5:0] ctrl; logic [5:0] ev; logic [5:0] flg;} epac_row_t;
   // Flags: reset, dtr, cts, attached, prompt, grant.
   localparam epac_row_t ROWS [15] = '{
      '{6'h04, 6'h00, 6'h10}, '{6'h14, 6'h02, 6'h1D}, '{6'h14, 6'h08, 6'h10},
      '{6'h06, 6'h02, 6'h1D}, '{6'h06, 6'h08, 6'h10}, '{6'h01, 6'h01, 6'h28},
      '{6'h00, 6'h01, 6'h0E}, '{6'h00, 6'h04, 6'h0E}, '{6'h00, 6'h20, 6'h0C},
      '{6'h00, 6'h10, 6'h0E}, '{6'h00, 6'h20, 6'h0C}, '{6'h00, 6'h08, 6'h00},
      '{6'h08, 6'h00, 6'h38}, '{6'h08, 6'h02, 6'h1D}, '{6'h08, 6'h08, 6'h10}};
   logic clk_sys = 1'h0;
   logic srst = 1'h1;
   logic hsel = 1'h0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic hready;
   logic hreadyout, hresp, dtr_in, cts_out, dsr_out, dcd_out;
   logic prompt_pulse, grant_pulse, attached;
   logic [31:0] hrdata, rd;
   logic dtr_req = 1'h0;
   logic lo;
   int bad_count = 0;
   int num_checks = 0;
   int np = 0;
   int ng = 0;
   int n = 0;
   assign hready = hreadyout;
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      if (prompt_pulse === 1'h1)
         np++;
      if (grant_pulse === 1'h1)
         ng++;
   end
   epac_attach_ctrl #(.TOGGLE_CYCLES(24'h000014)) DUT (.clk_sys(clk_sys), .srst(srst),
      .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dtr_in(dtr_in),
      .cts_out(cts_out), .dsr_out(dsr_out), .dcd_out(dcd_out),
      .prompt_pulse(prompt_pulse), .grant_pulse(grant_pulse), .attached(attached));
   epac_term_model u_term (.clk_sys(clk_sys), .cts_out(cts_out), .dsr_out(dsr_out),
      .dcd_out(dcd_out), .dtr_in(dtr_in), .dtr_req(dtr_req));
   task complete_run();
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'h1)
      begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'h1 && n < 64)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 64)
      begin
         chk(1'h0, "bus timeout");
         complete_run();
      end
   endtask : wait_rdy
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge clk_sys);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask : xfer
   task automatic do_reset();
      @(posedge clk_sys);
      srst <= 1'h1;
      repeat (4) @(posedge clk_sys);
      srst <= 1'h0;
   endtask : do_reset
   initial
   begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'h0;
      foreach (ROWS[i])
      begin
         if (ROWS[i].flg[5])
            do_reset();
         dtr_req <= ROWS[i].flg[4];
         xfer(EPAC_CTRL_ADDR, 1'h1, {26'h0, ROWS[i].ctrl}, rd);
         np = 0;
         ng = 0;
         if (ROWS[i].ev != 6'h00)
            xfer(EPAC_EVENT_ADDR, 1'h1, {26'h0, ROWS[i].ev}, rd);
         repeat (4) @(posedge clk_sys);
         #1;
         chk(cts_out === ROWS[i].flg[3], "cts level");
         chk(dsr_out === cts_out && dcd_out === 1'h1, "dsr or dcd");
         chk(attached === ROWS[i].flg[2], "attached");
         chk(np == int'(ROWS[i].flg[1]), "prompt count");
         chk(ng == int'(ROWS[i].flg[0]), "grant count");
      end
      xfer(EPAC_STATUS_ADDR, 1'h0, 32'h00000000, rd);
      chk(rd[4:0] === {EPAC_ST_TOGGLE, 2'h0}, "status");
      n = 0;
      while (cts_out !== 1'h1 && n < 64)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      lo = (n > 8) && (n < 64) && (attached === 1'h0);
      chk(lo, "toggle not back to high neutral");
      if (n == 64)
         complete_run();
      xfer(EPAC_TOGGLE_ADDR, 1'h0, 32'h00000000, rd);
      chk(rd === 32'h00989680, "toggle count");
      @(posedge clk_sys);
      srst <= 1'h1;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(cts_out === 1'h0 && dcd_out === 1'h1, "reset levels");
      srst <= 1'h0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(cts_out === 1'h1 && attached === 1'h0, "neutral after reset");
      xfer(8'h14, 1'h1, 32'hFFFFFFFF, rd);
      xfer(EPAC_CTRL_ADDR, 1'h0, 32'h00000000, rd);
      chk(rd === {26'h0, EPAC_CTRL_RESET}, "ctrl reset value");
      xfer(8'h10, 1'h0, 32'h00000000, rd);
      chk(rd === 32'h00000000, "unmapped read");
      complete_run();
   end
endmodule : epac_attach_ctrl_tb
